// File: design/adc_convert_control.v
// Overview of operation
// RULE1 - Convert pin rise starts conversion at second conversion-clock falling edge.
// RULE2 - Host keeps convert pin low, then high, two conversion-clock periods each.
// RULE3 - Busy rises one converter-clock period after start, falls at completion.
// RULE4 - Pin start during a conversion abandons it and restarts fresh.
// RULE5 - Pin start is accepted whatever the chip select level.
// RULE6 - Two-bit read-back mode: explicit, high first, low first, high only.
// RULE7 - Only serial starts arm automatic read-back, never pin starts.
// RULE8 - High-byte-only mode still runs the full conversion.
// RULE9 - First bit latched on first active edge, rest on next inactive edge.
// RULE10 - Host avoids completions between first active and next inactive edge.
// RULE11 - Explicit reads: 16-bit addr 1 high first, addr 0 low first, 8-bit high.
// RULE12 - Read returns last result completed before first active data edge.
// RULE13 - Mode 1 acts as implied 16-bit read of address 1 after serial start.
// RULE14 - Auto read-back outputs last completed result, conversion running or not.
// RULE15 - Mode 2 is mode 1 but reads address 0, low byte first.
// RULE16 - Host waits for busy low with chip select held to get new result.
// RULE17 - Serial output carries no valid data before its active clock edge.
// RULE18 - Serial port is half duplex: read or write, never both.
// RULE19 - Full-duplex hosts keep two-wire, low-bit-first, early-release cleared.
// RULE20 - Byte-serial hosts set those selects first and tie edge polarity high.
// RULE21 - Host enables internal reference and oscillator after every reset.
// RULE22 - Serial start while running waits in a one-deep, replaceable queue.
// RULE23 - Converter clock is 1, 2, 4 or 8 conversion-clock periods.
// RULE24 - Aborted conversion keeps last completed result, partial result dropped.
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"

module adc_convert_control #(
   parameter CONV_BIT_CLOCKS = `CONV_BIT_CLOCKS
) (
   // Clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // Converter timing and core
   input  wire        conversion_clock,
   input  wire        convert_pin,
   input  wire [11:0] core_result,
   // Configuration
   input  wire        readback_mode_hi,
   input  wire        readback_mode_lo,
   input  wire        clock_divider_hi,
   input  wire        clock_divider_lo,
   input  wire        lsb_first,
   input  wire        two_wire_select,
   input  wire        early_release,
   input  wire        sclk_rising_active,
   // Decoded serial requests
   input  wire        serial_start,
   input  wire        read_req,
   input  wire        read_addr,
   input  wire        read_16,
   // Serial pins
   input  wire        cs_n,
   input  wire        sclk,
   output reg         dout_o,
   output reg         dout_oe,
   output reg         din_o,
   output reg         din_oe,
   // Status
   output reg         start_busy_bit,
   output reg         busy,
   output reg  [11:0] result,
   output reg         read_active
);

   // ------------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------------
   function [7:0] reverse8;
      input [7:0] v;
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            reverse8[i] = v[7 - i];
         end
      end
   endfunction

   // Word in transmission order, first bit at the top
   function [15:0] order_word;
      input [11:0] res;
      input        hi_first;
      input        lsbf;
      reg   [7:0]  a;
      reg   [7:0]  b;
      begin
         a = hi_first ? res[11:4] : {res[3:0], 4'h0};
         b = hi_first ? {res[3:0], 4'h0} : res[11:4];
         order_word = {(lsbf ? reverse8(a) : a), (lsbf ? reverse8(b) : b)};
      end
   endfunction

   // ------------------------------------------------------------------
   // Edge detection on synchronous inputs
   // ------------------------------------------------------------------
   reg         conversion_clock_prev_q;
   reg         pin_prev_q;
   reg         sclk_prev_q;
   wire        conversion_clock_fall = conversion_clock_prev_q & ~conversion_clock;
   wire        pin_rise  = ~pin_prev_q & convert_pin;
   wire        sclk_rise = ~sclk_prev_q & sclk;
   wire        sclk_fall = sclk_prev_q & ~sclk;
   wire        act_edge  = sclk_rising_active ? sclk_rise : sclk_fall;
   wire        inact_edge = sclk_rising_active ? sclk_fall : sclk_rise;
   wire [1:0]  rb_mode   = {readback_mode_hi, readback_mode_lo};  // see RULE6
   wire [1:0]  div_sel   = {clock_divider_hi, clock_divider_lo};

   always @(posedge clk) begin
      if (!reset_n) begin
         conversion_clock_prev_q <= 1'b0;
         pin_prev_q  <= 1'b0;
         sclk_prev_q <= 1'b0;
      end else begin
         conversion_clock_prev_q <= conversion_clock;
         pin_prev_q  <= convert_pin;
         sclk_prev_q <= sclk;
      end
   end

   // ------------------------------------------------------------------
   // Start scheduling
   // ------------------------------------------------------------------
   // Pin and serial starts wait separately so a pin start is never lost
   reg  [1:0]  pin_wait_q;
   reg         pin_pend_q;
   reg  [1:0]  ser_wait_q;
   reg         ser_pend_q;
   reg         queued_q;
   reg         running_q;
   reg  [3:0]  div_cnt_q;
   reg  [7:0]  bit_cnt_q;

   wire [3:0]  div_len   = (4'h1 << div_sel);                    // see RULE23
   wire        converter_bit_clock_tick = running_q & conversion_clock_fall & (div_cnt_q == div_len - 4'h1);
   wire        pin_go    = pin_pend_q & conversion_clock_fall & (pin_wait_q == `START_FALL_EDGES - 2'h1);
   wire        ser_go    = ser_pend_q & conversion_clock_fall & (ser_wait_q == `START_FALL_EDGES - 2'h1);
   // Full length in every mode, no short cycle for high-byte-only
   wire        finish    = converter_bit_clock_tick & (bit_cnt_q == CONV_BIT_CLOCKS[7:0] - 8'h1); // see RULE8
   // A serial start landing on the completion edge is never lost
   wire        start_now = pin_go | (finish & queued_q)
                           | (ser_go & (~running_q | finish));

   always @(posedge clk) begin
      if (!reset_n) begin
         pin_wait_q     <= 2'h0;
         pin_pend_q     <= 1'b0;
         ser_wait_q     <= 2'h0;
         ser_pend_q     <= 1'b0;
         queued_q       <= 1'b0;
         running_q      <= 1'b0;
         div_cnt_q      <= 4'h0;
         bit_cnt_q      <= 8'h0;
         busy           <= 1'b0;
         start_busy_bit <= 1'b0;
         result         <= 12'h000;
      end else begin
         // Chip select plays no part in pin starts
         if (pin_rise) begin                                     // see RULE5
            pin_pend_q <= 1'b1;
            pin_wait_q <= 2'h0;
         end else if (pin_go) begin
            pin_pend_q <= 1'b0;
         end else if (pin_pend_q && conversion_clock_fall) begin
            pin_wait_q <= pin_wait_q + 2'h1;                     // see RULE1
         end
         if (serial_start) begin
            ser_pend_q <= 1'b1;
            ser_wait_q <= 2'h0;
         end else if (ser_go) begin
            ser_pend_q <= 1'b0;
         end else if (ser_pend_q && conversion_clock_fall) begin
            ser_wait_q <= ser_wait_q + 2'h1;
         end
         // One-deep queue; a newer request simply overwrites the flag
         if (ser_go && running_q && !(finish && !queued_q)) begin
            queued_q <= 1'b1;                                    // see RULE22
         end else if (start_now && !pin_go) begin
            queued_q <= 1'b0;
         end
         if (start_now) begin
            // A pin start throws away the running conversion
            running_q <= 1'b1;                                   // see RULE4
            div_cnt_q <= 4'h0;
            bit_cnt_q <= 8'h0;
            busy      <= 1'b0;
         end else if (finish) begin
            running_q <= 1'b0;
            busy      <= 1'b0;                                   // see RULE3
         end else if (running_q && conversion_clock_fall) begin
            if (converter_bit_clock_tick) begin
               div_cnt_q <= 4'h0;
               bit_cnt_q <= bit_cnt_q + 8'h1;
               busy      <= 1'b1;                                // see RULE3
            end else begin
               div_cnt_q <= div_cnt_q + 4'h1;
            end
         end
         // Only a completed conversion reaches the result register
         if (finish && !pin_go) begin
            result <= core_result;                               // see RULE24
         end
         start_busy_bit <= running_q | queued_q | ser_pend_q;
      end
   end

   // ------------------------------------------------------------------
   // Read-back shifter
   // ------------------------------------------------------------------
   localparam RD_IDLE  = 3'h0;
   localparam RD_ARMED = 3'h1;
   localparam RD_FIRST = 3'h2;
   localparam RD_SHIFT = 3'h3;
   localparam RD_LAST  = 3'h4;

   reg  [2:0]  rd_state_q;
   reg         hi_first_q;
   reg         len16_q;
   reg  [15:0] shift_q;
   reg  [4:0]  left_q;

   wire [15:0] live_word = order_word(result, hi_first_q, lsb_first);
   wire [4:0]  len_bits  = len16_q ? 5'h10 : 5'h08;

   always @(posedge clk) begin
      if (!reset_n) begin
         rd_state_q  <= RD_IDLE;
         hi_first_q  <= 1'b1;
         len16_q     <= 1'b1;
         shift_q     <= 16'h0000;
         left_q      <= 5'h00;
         dout_o      <= 1'b0;
         dout_oe     <= 1'b0;
         din_o       <= 1'b0;
         din_oe      <= 1'b0;
         read_active <= 1'b0;
      end else begin
         case (rd_state_q)
            RD_IDLE: begin
               // Pin starts never arm read-back
               if (serial_start && rb_mode != `RBM_EXPLICIT) begin   // see RULE7
                  rd_state_q <= RD_ARMED;
                  // Mode 1 and 3 read address 1, mode 2 reads address 0
                  hi_first_q <= (rb_mode != `RBM_LOW_FIRST);     // see RULE13
                  len16_q    <= (rb_mode != `RBM_HIGH_ONLY);     // see RULE15
               end else if (read_req) begin
                  rd_state_q <= RD_ARMED;
                  hi_first_q <= (read_addr == `RESULT_ADDR_HIGH); // see RULE11
                  len16_q    <= read_16;
               end
            end
            RD_ARMED: begin
               // Sampled at the edge itself, running conversion or not
               if (act_edge && !cs_n) begin
                  dout_o     <= live_word[15];                   // see RULE9
                  din_o      <= live_word[15];
                  dout_oe    <= 1'b1;                            // see RULE17
                  din_oe     <= two_wire_select;
                  left_q     <= len_bits - 5'h1;
                  rd_state_q <= RD_FIRST;                        // see RULE14
               end
            end
            RD_FIRST: begin
               // Remaining bits snap the result one half cycle later
               if (inact_edge) begin
                  shift_q    <= {live_word[14:0], 1'b0};         // see RULE12
                  rd_state_q <= RD_SHIFT;
               end
            end
            RD_SHIFT: begin
               if (act_edge) begin
                  dout_o  <= shift_q[15];
                  din_o   <= shift_q[15];
                  shift_q <= {shift_q[14:0], 1'b0};
                  left_q  <= left_q - 5'h1;
                  if (left_q == 5'h01) begin
                     rd_state_q <= RD_LAST;
                  end
               end
            end
            RD_LAST: begin
               // Early release frees the line on the active edge
               if ((early_release && act_edge) || (!early_release && inact_edge)) begin
                  dout_oe    <= 1'b0;
                  din_oe     <= 1'b0;
                  rd_state_q <= RD_IDLE;
               end
            end
            default: begin
               rd_state_q <= RD_IDLE;
            end
         endcase
         // Deselect ends any read phase except the armed wait for the first active edge
         if (cs_n && rd_state_q != RD_IDLE && rd_state_q != RD_ARMED) begin
            dout_oe    <= 1'b0;
            din_oe     <= 1'b0;
            rd_state_q <= RD_IDLE;
         end
         // Drivers only in a read phase, so no write overlaps
         read_active <= (rd_state_q != RD_IDLE);                 // see RULE18
      end
   end

endmodule // adc_convert_control

// File: common/adc_ctrl_defines.vh
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// ----------------------------------------------------------------------
// Read-back modes (two-bit field, control register address 3)
// ----------------------------------------------------------------------
`define CTRL_REG_ADDR      5'h03
`define RBM_EXPLICIT       2'h0
`define RBM_HIGH_FIRST     2'h1
`define RBM_LOW_FIRST      2'h2
`define RBM_HIGH_ONLY      2'h3

// ----------------------------------------------------------------------
// Result addresses for explicit reads
// ----------------------------------------------------------------------
`define RESULT_ADDR_LOW    1'h0
`define RESULT_ADDR_HIGH   1'h1

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define START_FALL_EDGES   2'h2
`define CONV_BIT_CLOCKS    16
`define RESULT_BITS        12
`define WORD_BITS          16
`define BYTE_BITS          8

`endif

// File: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
   // Clock and request
   input  wire        clk,
   input  wire        go,
   input  wire [4:0]  nbits,
   // Serial pins
   output reg         sclk,
   output reg         cs_n,
   input  wire        dout_o,
   input  wire        dout_oe,
   // Received word
   output reg  [15:0] word,
   output reg         done
);
   integer k;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      word = 16'h0000;
      done = 1'b0;
   end
   // Clock idles low outside frames; a released line floats up to its pull-up
   always @(posedge clk) begin
      if (go) begin
         cs_n <= 1'b0;
         word <= 16'h0000;
         for (k = 0; k < nbits; k = k + 1) begin
            repeat (6) @(posedge clk);
            sclk <= 1'b1;
            repeat (6) @(posedge clk);
            word <= {word[14:0], dout_oe ? dout_o : 1'b1};
            sclk <= 1'b0;
         end
         repeat (6) @(posedge clk);
         cs_n <= 1'b1;
         done <= 1'b1;
         @(posedge clk);
         done <= 1'b0;
      end
   end
endmodule // host_model

// File: tb/adc_convert_control_chk.sv
`timescale 1ns/1ps
module adc_convert_control_chk #(
   parameter CONV_BIT_CLOCKS = 16
) (
   input wire        clk,
   input wire        reset_n,
   input wire        convert_pin,
   input wire        two_wire_select,
   input wire        sclk_rising_active,
   input wire        serial_start,
   input wire        read_req,
   input wire        cs_n,
   input wire        sclk,
   input wire        dout_o,
   input wire        dout_oe,
   input wire        din_oe,
   input wire        start_busy_bit,
   input wire        busy,
   input wire [11:0] result,
   input wire        read_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence pin_rise_s; $rose(convert_pin) && !start_busy_bit && !busy; endsequence
   sequence cs_idle_s; cs_n [*3]; endsequence
   AST_PIN_START_DELAY: assert property (pin_rise_s |-> !busy [*4])
      else $error("busy rose too soon after pin start");
   AST_RESULT_AT_END: assert property ($changed(result) |-> $fell(busy))
      else $error("result changed outside a completion");
   AST_BUSY_RUNNING: assert property (busy |-> start_busy_bit)
      else $error("busy without a running conversion");
   AST_OE_NEEDS_CS: assert property ($rose(dout_oe) |-> !$past(cs_n))
      else $error("output driven without chip select");
   AST_CS_ABORT: assert property (cs_idle_s |-> !dout_oe)
      else $error("output still driven with chip select high");
   AST_BIT_ON_ACTIVE: assert property ($changed(dout_o) && dout_oe && $past(dout_oe)
      |-> sclk == sclk_rising_active) else $error("data bit moved off the active edge");
   AST_HALF_DUPLEX: assert property (din_oe |-> two_wire_select)
      else $error("data input line driven in three-wire use");
   AST_ARMED_BY_REQ: assert property ($rose(read_active) |->
      $past(serial_start || read_req) || $past(serial_start || read_req, 2))
      else $error("read phase without a serial request");
endmodule // adc_convert_control_chk

bind adc_convert_control adc_convert_control_chk #(.CONV_BIT_CLOCKS(CONV_BIT_CLOCKS)) chk (
   .clk(clk), .reset_n(reset_n), .convert_pin(convert_pin), .two_wire_select(two_wire_select),
   .sclk_rising_active(sclk_rising_active), .serial_start(serial_start), .read_req(read_req),
   .cs_n(cs_n), .sclk(sclk), .dout_o(dout_o), .dout_oe(dout_oe), .din_oe(din_oe),
   .start_busy_bit(start_busy_bit), .busy(busy), .result(result), .read_active(read_active));

// File: tb/adc_convert_control_test.sv
`timescale 1ns/1ps
module adc_convert_control_test;
   reg         clk = 1'b0, reset_n = 1'b0, cc = 1'b0, pin = 1'b0, bq = 1'b0, go = 1'b0;
   reg         lsbf = 1'b0, sst = 1'b0, rrq = 1'b0, raddr = 1'b0, r16 = 1'b0, ser = 1'b0;
   reg  [11:0] core = 12'h1b7;
   reg  [1:0]  mode = 2'h0, div = 2'h0, ccn = 2'h0;
   reg  [4:0]  nb = 5'h10;
   reg  [15:0] ex;
   reg  [21:0] rows [0:7];
   wire        sclk, cs_n, dout_o, dout_oe, din_o, din_oe, sbb, busy, ract, done;
   wire [11:0] result;
   wire [15:0] word;
   integer     bad_count = 0, n_checks = 0, cyc = 0, falls = 0, i, t0, base, f0;
   adc_convert_control #(.CONV_BIT_CLOCKS(2)) DUT (.clk(clk), .reset_n(reset_n),
      .conversion_clock(cc), .convert_pin(pin), .core_result(core),
      .readback_mode_hi(mode[1]), .readback_mode_lo(mode[0]), .clock_divider_hi(div[1]),
      .clock_divider_lo(div[0]), .lsb_first(lsbf), .two_wire_select(1'b1),
      .early_release(1'b0), .sclk_rising_active(1'b1), .serial_start(sst), .read_req(rrq),
      .read_addr(raddr), .read_16(r16), .cs_n(cs_n), .sclk(sclk), .dout_o(dout_o),
      .dout_oe(dout_oe), .din_o(din_o), .din_oe(din_oe), .start_busy_bit(sbb), .busy(busy),
      .result(result), .read_active(ract));
   host_model host (.clk(clk), .go(go), .nbits(nb), .sclk(sclk), .cs_n(cs_n),
      .dout_o(dout_o), .dout_oe(dout_oe), .word(word), .done(done));
   always #12.5 clk = ~clk;
   // ------------------------------------------------------------
   // Conversion clock, four system clocks a period; hang guard
   // ------------------------------------------------------------
   always @(posedge clk) begin
      ccn <= ccn + 2'h1;
      if (ccn[0]) cc <= ~cc;
      bq <= busy;
      if (bq && !busy) falls <= falls + 1;
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count = bad_count + 1;
         tally_and_finish;
      end
   end
   task check(input [15:0] seen, input [15:0] want, input [8*8-1:0] what);
      n_checks = n_checks + 1;
      if (seen !== want) begin
         bad_count = bad_count + 1;
         $display("MISMATCH %0s expected %h seen %h", what, want, seen);
      end
   endtask
   task tally_and_finish;
      $display("Checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task pulse(input s); // One-cycle decoded request
      @(posedge clk) if (s) sst <= 1'b1; else rrq <= 1'b1;
      @(posedge clk) {sst, rrq} <= 2'b00;
   endtask
   task pin_start; // Low and high for over two conversion-clock periods
      @(posedge clk) pin <= 1'b1;
      repeat (10) @(posedge clk);
      pin <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
   task wait_idle;
      repeat (3) @(posedge clk);
      while (sbb !== 1'b0) @(posedge clk);
   endtask
   task rd(input [4:0] bits);
      @(posedge clk) {nb, go} <= {bits, 1'b1};
      @(posedge clk) go <= 1'b0;
      @(posedge done);
      @(posedge clk);
   endtask
   initial begin
      // Rows: serial start, mode, address, 16-bit, low bit first, expected word
      rows[0] = {1'b0, 2'h0, 1'b1, 1'b1, 1'b0, 16'h1b70};
      rows[1] = {1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 16'h701b};
      rows[2] = {1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 16'h001b};
      rows[3] = {1'b1, 2'h1, 1'b1, 1'b1, 1'b0, 16'h1b70};
      rows[4] = {1'b1, 2'h2, 1'b0, 1'b1, 1'b0, 16'h701b};
      rows[5] = {1'b1, 2'h3, 1'b1, 1'b0, 1'b0, 16'h001b};
      rows[6] = {1'b0, 2'h0, 1'b1, 1'b1, 1'b1, 16'hd80e};
      rows[7] = {1'b1, 2'h2, 1'b0, 1'b1, 1'b1, 16'h0ed8};
      repeat (10) @(posedge clk);
      check({4'h0, result}, 16'h0000, "rstres");
      check({14'h0, busy, dout_oe}, 16'h0000, "rstout");
      reset_n <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin // Busy delay grows with the divider
         @(negedge cc) @(posedge clk) {div, pin} <= {i[1:0], 1'b1};
         t0 = cyc;
         while (busy !== 1'b1) @(posedge clk);
         if (i == 0) base = cyc - t0;
         check(16'(cyc - t0 - base), 16'((2 ** i - 1) * 4), "busydly");
         pin <= 1'b0;
         wait_idle;
      end
      check({4'h0, result}, 16'h01b7, "pinres");
      check({15'h0, ract}, 16'h0000, "pinread");
      div <= 2'h0;
      for (i = 0; i < 8; i = i + 1) begin
         @(posedge clk) {ser, mode, raddr, r16, lsbf, ex} <= rows[i];
         pulse(rows[i][21]);
         rd(r16 ? 5'h10 : 5'h08);
         check(word, ex, "rdword");
         wait_idle;
         $display("Row %0d done", i);
      end
      // Read races a new conversion; old result must come back
      // Slower converter clock keeps completion clear of the first inactive edge
      @(posedge clk) {lsbf, mode, core, div} <= {1'b0, 2'h1, 12'h2e4, 2'h1};
      pulse(1'b1);
      rd(5'h10); // Completion falls after the first inactive edge
      check(word, 16'h1b70, "oldres");
      wait_idle;
      check({4'h0, result}, 16'h02e4, "newres");
      $display("Overlap test done");
      @(posedge clk) mode <= 2'h0;
      pulse(1'b1);
      while (busy !== 1'b1) @(posedge clk);
      f0 = falls;
      pulse(1'b1);
      pulse(1'b1);
      wait_idle;
      check(16'(falls - f0), 16'h0002, "queue");
      $display("Queue test done");
      @(posedge clk) {div, core} <= {2'h3, 12'h555};
      pin_start;
      repeat (20) @(posedge clk);
      pin_start;
      repeat (30) @(posedge clk);
      check({4'h0, result}, 16'h02e4, "abortres");
      check({15'h0, busy}, 16'h0001, "abortbsy");
      wait_idle;
      check({4'h0, result}, 16'h0555, "restart");
      $display("Abort test done");
      tally_and_finish;
   end
endmodule // adc_convert_control_test
